// ### irq_enable_and_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
module irq_enable_and_flag_bank
  import irq_bank_pkg::*;
(
  input  wire logic [ADDR_W-1:0]    i_addr,               // register address
  input  wire logic [DATA_W-1:0]    i_wr_data,            // write data
  input  wire logic                 i_wr_stb,             // write strobe
  input  wire logic                 i_rd_stb,             // read strobe
  output logic      [DATA_W-1:0]    o_rd_data,            // read data, cycle after strobe
  input  wire logic                 i_clk_sys,            // 20 MHz system clock
  input  wire logic                 i_rst,                // async reset, high
  input  wire logic                 i_timer_b1_wrap,      // timer b1 0xff->0x00 pulse
  input  wire logic                 i_timer_a_wrap,       // timer a 0xff->0x00 pulse
  input  wire logic                 i_sleep_exec,         // sleep instruction pulse
  input  wire logic                 i_direct_xfer_on_bit, // direct transfer on level
  input  wire logic                 i_converter_busy_bit, // converter busy level
  input  wire logic                 i_serial1_done,       // serial channel one done pulse
  input  wire logic [EDGE_PINS-1:0] i_edge_pin_irq_mode,  // pin set to interrupt input
  input  wire logic [EDGE_PINS-1:0] i_edge_request_pins,  // async edge request pins
  input  wire logic [EXT_LINES-1:0] i_external_line_pins, // async external line pads
  output logic      [REQ_W-1:0]     o_irq_req             // gated requests to priority logic
);
  logic [DATA_W-1:0] edge_pol_r;
  logic [DATA_W-1:0] line_pol_r;
  logic [DATA_W-1:0] en_timer_pin_r;
  logic [DATA_W-1:0] en_periph_r;
  logic [DATA_W-1:0] en_ext_line_r;
  logic [DATA_W-1:0] pend_timer_pin_r;
  logic [DATA_W-1:0] pend_periph_r;
  logic [DATA_W-1:0] pend_ext_line_r;
  logic [DATA_W-1:0] pend_timer_pin_nxt;
  logic [DATA_W-1:0] pend_periph_nxt;
  logic [DATA_W-1:0] pend_ext_line_nxt;
  logic [DATA_W-1:0] set_timer_pin;
  logic [DATA_W-1:0] set_periph;
  logic [DATA_W-1:0] rd_nxt;
  logic              busy_prev_r;
  logic [REQ_W-1:0]  req_nxt;

  edge_bank_if #(.W(EDGE_PINS)) pin_if ();
  edge_bank_if #(.W(EXT_LINES)) line_if ();

  // true when this cycle writes the register at ofs
  function automatic logic wr_to(input logic [ADDR_W-1:0] ofs);
    return i_wr_stb && (i_addr == ofs);
  endfunction : wr_to

  // zero bits of a write clear, one bits leave the flag alone
  function automatic logic [DATA_W-1:0] upd_flags(input logic [DATA_W-1:0] cur,
                                                  input logic [DATA_W-1:0] set,
                                                  input logic              hit);
    logic [DATA_W-1:0] clr;
    clr = hit ? ~i_wr_data : '0;
    return (cur & ~clr) | set;
  endfunction : upd_flags

  //////////////////////////////////////////////////////////////////////////////
  // edge detectors: four request pins gated by mode, eight lines always armed
  assign pin_if.raw  = i_edge_request_pins;
  assign pin_if.pol  = edge_pol_r[EDGE_PINS-1:0];
  assign pin_if.arm  = i_edge_pin_irq_mode;
  assign line_if.raw = i_external_line_pins;
  assign line_if.pol = line_pol_r;
  assign line_if.arm = '1;

  // twelve external sources in two banks
  edge_sense_bank #(.W(EDGE_PINS)) u_pin_edges (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bank      (pin_if.det)
  );
  edge_sense_bank #(.W(EXT_LINES)) u_line_edges (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bank      (line_if.det)
  );

  //////////////////////////////////////////////////////////////////////////////
  // polarity registers, falling edge after reset
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      edge_pol_r <= RST_POL;
      line_pol_r <= RST_POL;
    end
    else
    begin
      if (wr_to(OFS_EDGE_POL))
        edge_pol_r <= i_wr_data & MASK_EDGE_POL;
      if (wr_to(OFS_LINE_POL))
        line_pol_r <= i_wr_data;
    end
  end

  // enable registers; unimplemented bits masked at write time
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      en_timer_pin_r <= RST_TIMER_PIN;
      en_periph_r    <= RST_PERIPH;
      en_ext_line_r  <= RST_EXT_LINE;
    end
    else
    begin
      if (wr_to(OFS_EN_TIMER_PIN))
        en_timer_pin_r <= (i_wr_data & MASK_TIMER_PIN) | FIXED_TIMER_PIN;
      if (wr_to(OFS_EN_PERIPH))
        en_periph_r <= i_wr_data & MASK_PERIPH;
      if (wr_to(OFS_EN_EXT_LINE))
        en_ext_line_r <= i_wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // busy level is same-clock logic, so its fall is seen without syncing
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      busy_prev_r <= 1'b0;
    else
      busy_prev_r <= i_converter_busy_bit;
  end

  // hardware set terms per register
  always_comb
  begin
    set_timer_pin                       = '0;
    set_timer_pin[BIT_TIMER_B1]         = i_timer_b1_wrap;
    set_timer_pin[BIT_TIMER_A]          = i_timer_a_wrap;
    set_timer_pin[EDGE_PINS-1:0]        = pin_if.hit;
    set_periph                          = '0;
    set_periph[BIT_DIRECT]              = i_sleep_exec & i_direct_xfer_on_bit;
    set_periph[BIT_CONV]                = busy_prev_r & ~i_converter_busy_bit;
    set_periph[BIT_SERIAL1]             = i_serial1_done;
  end

  // next flag values; no acceptance input exists, only writes clear
  always_comb
  begin
    pend_timer_pin_nxt = (upd_flags(pend_timer_pin_r, set_timer_pin, wr_to(OFS_PEND_TIMER_PIN))
                          & MASK_TIMER_PIN) | FIXED_TIMER_PIN;
    pend_periph_nxt    = upd_flags(pend_periph_r, set_periph, wr_to(OFS_PEND_PERIPH))
                         & MASK_PERIPH;
    pend_ext_line_nxt  = upd_flags(pend_ext_line_r, line_if.hit, wr_to(OFS_PEND_EXT_LINE));
  end

  // pending flag registers
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend_timer_pin_r <= RST_TIMER_PIN;
      pend_periph_r    <= RST_PERIPH;
      pend_ext_line_r  <= RST_EXT_LINE;
    end
    else
    begin
      pend_timer_pin_r <= pend_timer_pin_nxt;
      pend_periph_r    <= pend_periph_nxt;
      pend_ext_line_r  <= pend_ext_line_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_nxt = '0;
    unique case (i_addr)
      OFS_EDGE_POL:       rd_nxt = edge_pol_r;
      OFS_LINE_POL:       rd_nxt = line_pol_r;
      OFS_EN_TIMER_PIN:   rd_nxt = en_timer_pin_r;
      OFS_EN_PERIPH:      rd_nxt = en_periph_r;
      OFS_EN_EXT_LINE:    rd_nxt = en_ext_line_r;
      OFS_PEND_TIMER_PIN: rd_nxt = pend_timer_pin_r;
      OFS_PEND_PERIPH:    rd_nxt = pend_periph_r;
      OFS_PEND_EXT_LINE:  rd_nxt = pend_ext_line_r;
      default:            rd_nxt = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_rd_data <= '0;
    else if (i_rd_stb)
      o_rd_data <= rd_nxt;
    else
      o_rd_data <= '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one request per source, flag and enable; adds one cycle of latency
  always_comb
  begin
    req_nxt                                     = '0;
    req_nxt[REQ_LINE_LO +: EXT_LINES]           = pend_ext_line_r & en_ext_line_r;
    req_nxt[REQ_EDGE_LO +: EDGE_PINS]           = pend_timer_pin_r[EDGE_PINS-1:0]
                                                  & en_timer_pin_r[EDGE_PINS-1:0];
    req_nxt[REQ_SERIAL1]  = pend_periph_r[BIT_SERIAL1] & en_periph_r[BIT_SERIAL1];
    req_nxt[REQ_CONV]     = pend_periph_r[BIT_CONV] & en_periph_r[BIT_CONV];
    req_nxt[REQ_DIRECT]   = pend_periph_r[BIT_DIRECT] & en_periph_r[BIT_DIRECT];
    req_nxt[REQ_TIMER_A]  = pend_timer_pin_r[BIT_TIMER_A] & en_timer_pin_r[BIT_TIMER_A];
    req_nxt[REQ_TIMER_B1] = pend_timer_pin_r[BIT_TIMER_B1] & en_timer_pin_r[BIT_TIMER_B1];
  end

  // request register toward the priority logic
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_irq_req <= '0;
    else
      o_irq_req <= req_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence rd_periph_en_s;
    i_rd_stb && (i_addr == OFS_EN_PERIPH);
  endsequence
  sequence rd_timer_pend_s;
    i_rd_stb && (i_addr == OFS_PEND_TIMER_PIN);
  endsequence
  sequence clr_b1_s;
    i_wr_stb && (i_addr == OFS_PEND_TIMER_PIN) && !i_wr_data[BIT_TIMER_B1];
  endsequence
  sequence serial1_on_s;
    i_wr_stb && (i_addr == OFS_EN_PERIPH) && i_wr_data[BIT_SERIAL1];
  endsequence

  rsv_enable_a: assert property (rd_periph_en_s |=> (o_rd_data[5] == 1'b0)
                                 && (o_rd_data[3:0] == 4'h0))
    else $error("reserved enable bits read nonzero");
  fixed_bits_a: assert property (rd_timer_pend_s |=> (o_rd_data[5:4] == 2'b01))
    else $error("fixed bits of timer pin pending wrong");
  set_wins_a: assert property (clr_b1_s and i_timer_b1_wrap
                               |=> pend_timer_pin_r[BIT_TIMER_B1])
    else $error("event lost against clear");
  zero_clear_a: assert property (clr_b1_s and !i_timer_b1_wrap
                                 |=> !pend_timer_pin_r[BIT_TIMER_B1])
    else $error("zero write did not clear flag");
  one_nosets_a: assert property (i_wr_stb && (i_addr == OFS_PEND_EXT_LINE) && (line_if.hit == '0)
                                 |=> ((pend_ext_line_r & ~$past(pend_ext_line_r)) == '0))
    else $error("software write set a flag");
  // a zero write right after the wrap may clear the flag legally
  timer_a_set_a: assert property (i_timer_a_wrap ##1 !wr_to(OFS_PEND_TIMER_PIN)
                                  |-> pend_timer_pin_r[BIT_TIMER_A][*2])
    else $error("timer a flag not set or not held");
  flag_holds_a: assert property (pend_periph_r[BIT_CONV] && !wr_to(OFS_PEND_PERIPH)
                                 |=> pend_periph_r[BIT_CONV])
    else $error("flag cleared without a write");
  direct_set_a: assert property (i_sleep_exec && i_direct_xfer_on_bit
                                 |=> pend_periph_r[BIT_DIRECT])
    else $error("direct transfer flag not set");
  conv_set_a: assert property ($fell(i_converter_busy_bit) |=> pend_periph_r[BIT_CONV])
    else $error("conversion done flag not set");
  line_set_a: assert property (line_if.hit[0] |=> pend_ext_line_r[0])
    else $error("external line flag not set");
  serial_req_a: assert property (serial1_on_s ##1 i_serial1_done
                                 |-> ##2 o_irq_req[REQ_SERIAL1])
    else $error("enabled serial request did not reach core");
  gate_req_a: assert property (##1 o_irq_req[REQ_TIMER_B1]
                               == ($past(pend_timer_pin_r[BIT_TIMER_B1])
                                   && $past(en_timer_pin_r[BIT_TIMER_B1])))
    else $error("timer b1 request not flag and enable");

  // per-source set paths, line flag hold, line enable write, idle read data and request gating
  b1_set_a: assert property (i_timer_b1_wrap |=> pend_timer_pin_r[BIT_TIMER_B1])
    else $error("timer b1 flag not set");
  serial_set_a: assert property (i_serial1_done |=> pend_periph_r[BIT_SERIAL1])
    else $error("serial one flag not set");
  sleep_plain_a: assert property (i_sleep_exec && !i_direct_xfer_on_bit && !pend_periph_r[BIT_DIRECT]
                                  |=> !pend_periph_r[BIT_DIRECT])
    else $error("sleep without direct transfer set the flag");
  pin_flag_a: assert property ((pin_if.hit != '0)
                               |=> ((pend_timer_pin_r[EDGE_PINS-1:0] & $past(pin_if.hit)) == $past(pin_if.hit)))
    else $error("edge pin hit did not set its flag");
  line_flags_a: assert property ((line_if.hit != '0)
                                 |=> ((pend_ext_line_r & $past(line_if.hit)) == $past(line_if.hit)))
    else $error("line hit did not set its flag");
  line_hold_a: assert property (pend_ext_line_r[4] && !wr_to(OFS_PEND_EXT_LINE)
                                |=> pend_ext_line_r[4])
    else $error("line flag cleared without a write");
  ext_en_wr_a: assert property (wr_to(OFS_EN_EXT_LINE) |=> (en_ext_line_r == $past(i_wr_data)))
    else $error("line enable write not taken");
  rd_idle_a: assert property (!i_rd_stb |=> (o_rd_data == '0))
    else $error("read data left standing");
  req_line_a: assert property (##1 o_irq_req[REQ_LINE_LO +: EXT_LINES]
                               == ($past(pend_ext_line_r) & $past(en_ext_line_r)))
    else $error("line requests not flag and enable");
  req_pin_a: assert property (##1 o_irq_req[REQ_EDGE_LO +: EDGE_PINS]
                              == ($past(pend_timer_pin_r[EDGE_PINS-1:0]) & $past(en_timer_pin_r[EDGE_PINS-1:0])))
    else $error("edge pin requests not flag and enable");
endmodule : irq_enable_and_flag_bank
`default_nettype wire

// ### irq_bank_pkg.sv
`default_nettype none
package irq_bank_pkg;
  localparam int          ADDR_W             = 4;
  localparam int          DATA_W             = 8;
  localparam int          EDGE_PINS          = 4;
  localparam int          EXT_LINES          = 8;
  localparam int          REQ_W              = 17;
  // register offsets
  localparam logic [3:0]  OFS_EDGE_POL       = 4'h0;
  localparam logic [3:0]  OFS_LINE_POL       = 4'h1;
  localparam logic [3:0]  OFS_EN_TIMER_PIN   = 4'h2;
  localparam logic [3:0]  OFS_EN_PERIPH      = 4'h3;
  localparam logic [3:0]  OFS_EN_EXT_LINE    = 4'h4;
  localparam logic [3:0]  OFS_PEND_TIMER_PIN = 4'h5;
  localparam logic [3:0]  OFS_PEND_PERIPH    = 4'h6;
  localparam logic [3:0]  OFS_PEND_EXT_LINE  = 4'h7;
  // reset values
  localparam logic [7:0]  RST_POL            = 8'h00;
  localparam logic [7:0]  RST_TIMER_PIN      = 8'h10;
  localparam logic [7:0]  RST_PERIPH         = 8'h00;
  localparam logic [7:0]  RST_EXT_LINE       = 8'h00;
  // implemented bits and fixed-one bits
  localparam logic [7:0]  MASK_EDGE_POL      = 8'h0f;
  localparam logic [7:0]  MASK_TIMER_PIN     = 8'hcf;
  localparam logic [7:0]  FIXED_TIMER_PIN    = 8'h10;
  localparam logic [7:0]  MASK_PERIPH        = 8'hd0;
  // field positions
  localparam int          BIT_TIMER_B1       = 7;
  localparam int          BIT_TIMER_A        = 6;
  localparam int          BIT_DIRECT         = 7;
  localparam int          BIT_CONV           = 6;
  localparam int          BIT_SERIAL1        = 4;
  // request vector layout
  localparam int          REQ_LINE_LO        = 0;
  localparam int          REQ_EDGE_LO        = 8;
  localparam int          REQ_SERIAL1        = 12;
  localparam int          REQ_CONV           = 13;
  localparam int          REQ_DIRECT         = 14;
  localparam int          REQ_TIMER_A        = 15;
  localparam int          REQ_TIMER_B1       = 16;
endpackage : irq_bank_pkg
`default_nettype wire

// ### edge_bank_if.sv
`timescale 1ns/10ps
`default_nettype none
// carries raw pin levels, edge choice and arming to a detector, hits back
interface edge_bank_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] pol;
  logic [W-1:0] arm;
  logic [W-1:0] hit;
  modport ctrl (output raw, output pol, output arm, input hit);
  modport det  (input raw, input pol, input arm, output hit);
endinterface : edge_bank_if
`default_nettype wire

// ### edge_sense_bank.sv
`timescale 1ns/10ps
`default_nettype none
module edge_sense_bank
  import irq_bank_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic  i_clk_sys,  // system clock
  input  wire logic  i_rst,      // async reset, high
  edge_bank_if.det   bank        // pins in, hits out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] hit_r;

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser; meta_r feeds sync_r only
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= bank.raw;
      sync_r <= meta_r;
    end
  end

  // history of the synchronised level for edge compare
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      prev_r <= '0;
    else
      prev_r <= sync_r;
  end

  // selected edge per bit; a pad edge counts only while its arm bit is set
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      hit_r <= '0;
    else
      hit_r <= bank.arm & ((bank.pol & sync_r & ~prev_r)
                         | (~bank.pol & ~sync_r & prev_r));
  end

  assign bank.hit = hit_r;

  //////////////////////////////////////////////////////////////////////////////
  armed_hit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (hit_r & ~$past(bank.arm)) == '0)
    else $error("edge hit on a pin that was not armed");
  fall_hit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 ((bank.arm & ~bank.pol & ~sync_r & prev_r) != '0) |=> (hit_r != '0))
    else $error("falling edge with falling polarity gave no hit");
endmodule : edge_sense_bank
`default_nettype wire

// ### periph_event_model.sv
`timescale 1ns/10ps
`default_nettype none
module periph_event_model
  import irq_bank_pkg::*;
(
  input  wire logic                 i_clk_sys,   // system clock
  output logic                      o_tb1,       // timer b1 wrap pulse
  output logic                      o_ta,        // timer a wrap pulse
  output logic                      o_sleep,     // sleep executed pulse
  output logic                      o_direct_xfer_on_bit,      // direct transfer on level
  output logic                      o_busy,      // converter busy level
  output logic                      o_s1,        // serial one done pulse
  output logic [EDGE_PINS-1:0]      o_mode,      // edge pins in irq mode
  output logic [EDGE_PINS-1:0]      o_epin,      // edge request pin levels
  output logic [EXT_LINES-1:0]      o_lpin       // external line pad levels
);
  ////////////////////////////////////////////////////////////////////////
  // quiet sources; pads idle high like low-true lines
  initial
  begin
    {o_tb1, o_ta, o_sleep, o_direct_xfer_on_bit, o_busy, o_s1} = 6'h00;
    o_mode = 4'h0;
    o_epin = 4'hf;
    o_lpin = 8'hff;
  end
  // one-cycle event: 0 timer b1, 1 timer a, 2 sleep, 3 serial one
  task automatic fire(input int k);
    @(posedge i_clk_sys);
    {o_tb1, o_ta, o_sleep, o_s1} <= 4'h8 >> k;
    @(posedge i_clk_sys);
    {o_tb1, o_ta, o_sleep, o_s1} <= 4'h0;
  endtask : fire
  // conversion runs a few cycles, then busy drops
  task automatic conv_done();
    @(posedge i_clk_sys);
    o_busy <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    o_busy <= 1'b0;
  endtask : conv_done
  task automatic set_direct_xfer_on_bit(input logic b);
    @(posedge i_clk_sys);
    o_direct_xfer_on_bit <= b;
  endtask : set_direct_xfer_on_bit
  // pads held two cycles at least so the synchronisers see them
  task automatic pins(input logic [3:0] e, input logic [7:0] l, input logic [3:0] m);
    @(posedge i_clk_sys);
    o_epin <= e;
    o_lpin <= l;
    o_mode <= m;
    repeat (6) @(posedge i_clk_sys);
  endtask : pins
endmodule : periph_event_model
`default_nettype wire

// ### irq_enable_and_flag_bank_bench.sv
`timescale 1ns/10ps
`default_nettype none
module irq_enable_and_flag_bank_bench;
  import irq_bank_pkg::*;
  logic                 clk, rst, wr_stb, rd_stb;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata;
  logic [DATA_W-1:0]    rd_data;
  logic [REQ_W-1:0]     irq_req;
  logic                 tb1, ta, slp, direct_xfer_on_bit, busy, s1;
  logic [3:0]           mode, epin;
  logic [7:0]           lpin;
  int                   failures, n_compared, cycles;
  ////////////////////////////////////////////////////////////////////////
  irq_enable_and_flag_bank u_dut (.i_addr(addr), .i_wr_data(wdata), .i_wr_stb(wr_stb),
    .i_rd_stb(rd_stb), .o_rd_data(rd_data), .i_clk_sys(clk), .i_rst(rst),
    .i_timer_b1_wrap(tb1), .i_timer_a_wrap(ta), .i_sleep_exec(slp),
    .i_direct_xfer_on_bit(direct_xfer_on_bit), .i_converter_busy_bit(busy), .i_serial1_done(s1),
    .i_edge_pin_irq_mode(mode), .i_edge_request_pins(epin),
    .i_external_line_pins(lpin), .o_irq_req(irq_req));
  periph_event_model u_src (.i_clk_sys(clk), .o_tb1(tb1), .o_ta(ta), .o_sleep(slp),
    .o_direct_xfer_on_bit(direct_xfer_on_bit), .o_busy(busy), .o_s1(s1), .o_mode(mode), .o_epin(epin), .o_lpin(lpin));
  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [REQ_W-1:0] seen, input logic [REQ_W-1:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    chk({9'h000, rd_data}, {9'h000, exp}, what);
  endtask : rd
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd(OFS_EDGE_POL, 8'h00, "edge pol");
    rd(OFS_LINE_POL, 8'h00, "line pol");
    rd(OFS_EN_TIMER_PIN, 8'h10, "en tp");
    rd(OFS_EN_PERIPH, 8'h00, "en per");
    rd(OFS_EN_EXT_LINE, 8'h00, "en ext");
    rd(OFS_PEND_TIMER_PIN, 8'h10, "pend tp");
    rd(OFS_PEND_PERIPH, 8'h00, "pend per");
    rd(OFS_PEND_EXT_LINE, 8'h00, "pend ext");
    chk(irq_req, '0, "req idle");
    $display("test reset done");
  endtask : test_reset
  task automatic test_regs();
    wr(OFS_EN_PERIPH, 8'hff);
    rd(OFS_EN_PERIPH, 8'hd0, "en per ones");
    wr(OFS_EN_PERIPH, 8'h2f);
    rd(OFS_EN_PERIPH, 8'h00, "en per rsv");
    wr(OFS_EN_EXT_LINE, 8'ha5);
    rd(OFS_EN_EXT_LINE, 8'ha5, "en ext a5");
    wr(OFS_EN_EXT_LINE, 8'h5a);
    rd(OFS_EN_EXT_LINE, 8'h5a, "en ext 5a");
    wr(OFS_EN_TIMER_PIN, 8'hff);
    rd(OFS_EN_TIMER_PIN, 8'hdf, "en tp ones");
    wr(OFS_EN_TIMER_PIN, 8'h00);
    rd(OFS_EN_TIMER_PIN, 8'h10, "en tp zero");
    // ones written to pending registers must not invent flags
    wr(OFS_PEND_TIMER_PIN, 8'hff);
    wr(OFS_PEND_PERIPH, 8'hff);
    wr(OFS_PEND_EXT_LINE, 8'hff);
    rd(OFS_PEND_TIMER_PIN, 8'h10, "tp ones");
    rd(OFS_PEND_PERIPH, 8'h00, "per ones");
    rd(OFS_PEND_EXT_LINE, 8'h00, "ext ones");
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00, "unmapped");
    wr(OFS_EN_EXT_LINE, 8'h00);
    $display("test regs done");
  endtask : test_regs
  task automatic test_events();
    wr(OFS_EN_TIMER_PIN, 8'hc0);
    wr(OFS_EN_PERIPH, 8'hd0);
    u_src.set_direct_xfer_on_bit(1'b0);
    u_src.fire(2);
    rd(OFS_PEND_PERIPH, 8'h00, "sleep no dt");
    u_src.set_direct_xfer_on_bit(1'b1);
    u_src.fire(2);
    // serial done one cycle after its enable write
    fork
      wr(OFS_EN_PERIPH, 8'hd0);
      begin
        @(posedge clk);
        u_src.fire(3);
      end
    join
    u_src.conv_done();
    u_src.fire(0);
    u_src.fire(1);
    rd(OFS_PEND_PERIPH, 8'hd0, "per flags");
    rd(OFS_PEND_TIMER_PIN, 8'hd0, "tp flags");
    chk(irq_req, 17'h1f000, "req all");
    wr(OFS_EN_PERIPH, 8'h00);
    repeat (3) @(negedge clk);
    chk(irq_req, 17'h18000, "req masked");
    rd(OFS_PEND_PERIPH, 8'hd0, "flags held");
    wr(OFS_PEND_PERIPH, 8'h7f);
    rd(OFS_PEND_PERIPH, 8'h50, "clear dt");
    // clear and timer b1 wrap on the same edge
    fork
      u_src.fire(0);
      wr(OFS_PEND_TIMER_PIN, 8'h10);
    join
    rd(OFS_PEND_TIMER_PIN, 8'h90, "set wins");
    wr(OFS_PEND_TIMER_PIN, 8'h00);
    wr(OFS_PEND_PERIPH, 8'h00);
    rd(OFS_PEND_PERIPH, 8'h00, "per clear");
    chk(irq_req, '0, "req gone");
    $display("test events done");
  endtask : test_events
  task automatic test_pins();
    wr(OFS_EN_TIMER_PIN, 8'h1f);
    u_src.pins(4'h0, 8'hff, 4'h0);
    rd(OFS_PEND_TIMER_PIN, 8'h10, "mode off");
    u_src.pins(4'hf, 8'hff, 4'hf);
    rd(OFS_PEND_TIMER_PIN, 8'h10, "rise ign");
    u_src.pins(4'ha, 8'hff, 4'hf);
    rd(OFS_PEND_TIMER_PIN, 8'h15, "fall hit");
    wr(OFS_PEND_TIMER_PIN, 8'h00);
    wr(OFS_EDGE_POL, 8'h0f);
    u_src.pins(4'h5, 8'hff, 4'hf);
    rd(OFS_PEND_TIMER_PIN, 8'h15, "rise hit");
    chk(irq_req, 17'h00500, "req pins");
    wr(OFS_EN_EXT_LINE, 8'h0f);
    u_src.pins(4'h5, 8'h0f, 4'hf);
    rd(OFS_PEND_EXT_LINE, 8'hf0, "line fall");
    chk(irq_req, 17'h00500, "line off");
    wr(OFS_LINE_POL, 8'hff);
    wr(OFS_PEND_EXT_LINE, 8'h00);
    u_src.pins(4'h5, 8'h00, 4'hf);
    rd(OFS_PEND_EXT_LINE, 8'h00, "line fall ign");
    u_src.pins(4'h5, 8'h0f, 4'hf);
    rd(OFS_PEND_EXT_LINE, 8'h0f, "line rise");
    chk(irq_req, 17'h0050f, "req lines");
    $display("test pins done");
  endtask : test_pins
  ////////////////////////////////////////////////////////////////////////
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      $display("MISMATCH t=%0t timeout", $time);
      print_verdict();
    end
  end
  initial
  begin
    {failures, n_compared, cycles} = '0;
    {wr_stb, rd_stb} = 2'b00;
    addr = 4'h0;
    wdata = 8'h00;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_regs();
    test_events();
    test_pins();
    print_verdict();
  end
endmodule : irq_enable_and_flag_bank_bench
`default_nettype wire
